// file: pab_pkg.sv
package pab_pkg;
   // Widths
   localparam int ADDR_W = 24;
   localparam int WORD_W = 32;
   localparam int CNT_W = 4;
   localparam int BLK_W = 7;
   localparam int PHYS_W = 4;
   localparam int SE_COUNT = 16;
   localparam int SLOTS = 10;
   localparam int REG_AW = 8;
   localparam int EV_W = 4;

   // Address fields: high part, counter part, block part, offset
   localparam int HI_MSB = 23;
   localparam int HI_LSB = 12;
   localparam int CNT_MSB = 22;
   localparam int CNT_LSB = 19;
   localparam int BLK_MSB = 18;
   localparam int BLK_LSB = 12;
   localparam int OFF_MSB = 11;
   localparam int ALIGN_MSB = 1;

   // Stepping limits
   localparam logic [CNT_W-1:0] STOP_SLOT = 4'h9;
   localparam logic [1:0] STOP_PASSES = 2'h2;

   // Register offsets
   localparam logic [REG_AW-1:0] REG_STATUS = 8'h00;
   localparam logic [REG_AW-1:0] REG_MASK = 8'h04;
   localparam logic [REG_AW-1:0] REG_CONFIG = 8'h08;
   localparam logic [REG_AW-1:0] REG_BASE = 8'h0c;
   localparam logic [REG_AW-1:0] REG_ATR0 = 8'h10;
   localparam int CFG_INHIBIT_LOGOUT_STOP_BIT_BIT = 16;
   localparam int BASE_ALT_BIT = 24;
   localparam int BASE_HALT_BIT = 25;

   // Status bit positions
   localparam int ST_SPEC = 0;
   localparam int ST_REJECT = 1;
   localparam int ST_STEPPED = 2;
   localparam int ST_ELC = 3;

   // Reset values
   localparam logic [SE_COUNT-1:0] CFG_RESET = 16'h0000;
   localparam logic [WORD_W-1:0] WORD_ZERO = 32'h0000_0000;

   typedef enum logic [1:0] {ST_IDLE, ST_STEP, ST_HALT} pab_step_e;

   typedef struct packed {
      logic valid;
      logic [PHYS_W-1:0] id;
   } pab_atr_s;

   typedef struct packed {
      logic valid;
      logic is_store;
      logic supervisor;
      logic native_mode;
      logic [ADDR_W-1:0] op_addr;
      logic [WORD_W-1:0] fetched;
   } pab_instr_req_s;

   typedef struct packed {
      logic done;
      logic spec_check;
      logic rejected;
      logic store_valid;
      logic [WORD_W-1:0] store_word;
   } pab_instr_rsp_s;

   typedef struct packed {
      logic valid;
      logic [ADDR_W-1:0] addr;
   } pab_access_req_s;

   typedef struct packed {
      logic valid;
      logic relocated;
      logic [ADDR_W-1:0] addr;
   } pab_access_rsp_s;
endpackage : pab_pkg

// file: pab_base_reloc.sv
// Operation
// - Load takes operand bits 8-19, ignores immediate
// - Load needs supervisor, native mode, word alignment
// - Load rejected if slot invalid or unconfigured
// - Load sets logical base, physical from slot
// - Physical base holds until load, restart, step
// - Store has same privilege and alignment checks
// - Store word: logical 8-19, physical 28-31
// - Stored counter bits show stepped value
// - Zero high bits relocate into 4096-byte area
// - Stepping moves whole element, same block
// - Every low address is forced through relocation
// - Stepping skips unconfigured elements, loads identifier
// - Alternate latch blocks stepping until load or restart
// - Step only with inhibit off and failure
// - Wraps; second pass at nine stops, zeroes
// - Alternate failure hardstops, freezes until load or restart
// - Relocated address: block logical, element physical
//
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/10ps
module pab_base_reloc #(
   parameter int N_SLOTS = pab_pkg::SLOTS
)
(
   // Clock and control
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ce,
   // Register port
   input wire logic [pab_pkg::REG_AW-1:0] reg_addr,
   input wire logic [pab_pkg::WORD_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [pab_pkg::WORD_W-1:0] reg_rdata,
   // Base instructions
   input pab_pkg::pab_instr_req_s instr_req,
   output pab_pkg::pab_instr_rsp_s instr_rsp,
   // Storage access path
   input pab_pkg::pab_access_req_s acc_req,
   output pab_pkg::pab_access_rsp_s acc_rsp,
   // Processor events
   input wire logic pref_fail,
   input wire logic restart_event,
   // Status outputs
   output logic hardstop,
   output logic element_check_signal,
   output logic irq
);

   pab_pkg::pab_atr_s addr_translation_table [N_SLOTS];
   logic [pab_pkg::SE_COUNT-1:0] cfg_mask;
   logic inhibit_logout_stop_bit;
   logic [pab_pkg::CNT_W-1:0] counter;
   logic [pab_pkg::BLK_W-1:0] blk;
   logic [pab_pkg::PHYS_W-1:0] phys;
   logic alt_latch;
   logic [1:0] nine_passes;
   pab_pkg::pab_step_e state;
   logic [pab_pkg::EV_W-1:0] status;
   logic [pab_pkg::EV_W-1:0] mask;
   logic [pab_pkg::EV_W-1:0] next_status;
   logic [pab_pkg::EV_W-1:0] events;

   function automatic logic slot_ok(input logic [pab_pkg::CNT_W-1:0] idx);
      logic ok;
      ok = 1'b0;
      if (int'(idx) < N_SLOTS)
      begin
         ok = addr_translation_table[idx].valid &&
              cfg_mask[addr_translation_table[idx].id];
      end
      return ok;
   endfunction : slot_ok

   function automatic logic [pab_pkg::PHYS_W-1:0] slot_id(
      input logic [pab_pkg::CNT_W-1:0] idx);
      logic [pab_pkg::PHYS_W-1:0] id;
      id = '0;
      if (int'(idx) < N_SLOTS)
      begin
         id = addr_translation_table[idx].id;
      end
      return id;
   endfunction : slot_id

   function automatic logic atr_hit(input logic [pab_pkg::REG_AW-1:0] a);
      return a >= pab_pkg::REG_ATR0 && a[1:0] == 2'b00 &&
             int'((a - pab_pkg::REG_ATR0) >> 2) < N_SLOTS;
   endfunction : atr_hit

   function automatic logic [pab_pkg::CNT_W-1:0] atr_index(
      input logic [pab_pkg::REG_AW-1:0] a);
      logic [pab_pkg::REG_AW-1:0] d;
      d = (a - pab_pkg::REG_ATR0) >> 2;
      return d[pab_pkg::CNT_W-1:0];
   endfunction : atr_index

   // Instruction decode; immediate field never looked at
   logic priv_ok;
   logic aligned;
   logic spec_bad;
   logic [pab_pkg::CNT_W-1:0] ld_cnt;
   logic load_go;
   logic ld_reject;
   logic store_go;
   logic fail_go;
   logic [pab_pkg::CNT_W-1:0] step_cnt;

   assign priv_ok = instr_req.supervisor && instr_req.native_mode;
   assign aligned = instr_req.op_addr[pab_pkg::ALIGN_MSB:0] == 2'b00;
   assign spec_bad = ce && instr_req.valid &&
                     !(priv_ok && aligned);
   assign ld_cnt = instr_req.fetched[pab_pkg::CNT_MSB:pab_pkg::CNT_LSB];
   assign load_go = ce && instr_req.valid && !instr_req.is_store &&
                    !spec_bad && slot_ok(ld_cnt);
   assign ld_reject = ce && instr_req.valid && !instr_req.is_store &&
                      !spec_bad && !slot_ok(ld_cnt);
   assign store_go = ce && instr_req.valid && instr_req.is_store && !spec_bad;
   assign fail_go = ce && pref_fail && !inhibit_logout_stop_bit &&
                    state == pab_pkg::ST_IDLE && !load_go &&
                    !restart_event;
   assign step_cnt = counter + 4'h1;

   // Base registers and stepping
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         counter <= '0;
         blk <= '0;
         phys <= '0;
         alt_latch <= 1'b0;
         nine_passes <= '0;
         state <= pab_pkg::ST_IDLE;
         hardstop <= 1'b0;
         element_check_signal <= 1'b0;
      end
      else if (ce)
      begin
         element_check_signal <= 1'b0;
         if (load_go)
         begin
            counter <= ld_cnt;
            blk <= instr_req.fetched[pab_pkg::BLK_MSB:pab_pkg::BLK_LSB];
            phys <= slot_id(ld_cnt);
            alt_latch <= 1'b0;
            nine_passes <= '0;
            state <= pab_pkg::ST_IDLE;
            hardstop <= 1'b0;
         end
         else if (restart_event)
         begin
            if (slot_ok(counter))
            begin
               phys <= slot_id(counter);
            end
            alt_latch <= 1'b0;
            nine_passes <= '0;
            state <= pab_pkg::ST_IDLE;
            hardstop <= 1'b0;
         end
         else
         begin
            case (state)
               pab_pkg::ST_IDLE:
               begin
                  if (fail_go && alt_latch)
                  begin
                     state <= pab_pkg::ST_HALT;
                     hardstop <= 1'b1;
                     element_check_signal <= 1'b1;
                  end
                  else if (fail_go)
                  begin
                     state <= pab_pkg::ST_STEP;
                     nine_passes <= '0;
                  end
               end
               pab_pkg::ST_STEP:
               begin
                  // One element per cycle; counter wraps from 15 to 0
                  counter <= step_cnt;
                  if (slot_ok(step_cnt))
                  begin
                     phys <= slot_id(step_cnt);
                     alt_latch <= 1'b1;
                     state <= pab_pkg::ST_IDLE;
                  end
                  else if (step_cnt == pab_pkg::STOP_SLOT)
                  begin
                     if (nine_passes == pab_pkg::STOP_PASSES - 2'h1)
                     begin
                        counter <= '0;
                        state <= pab_pkg::ST_HALT;
                        hardstop <= 1'b1;
                        element_check_signal <= 1'b1;
                     end
                     else
                     begin
                        nine_passes <= nine_passes + 2'h1;
                     end
                  end
               end
               pab_pkg::ST_HALT:
               begin
                  state <= pab_pkg::ST_HALT;
               end
               default:
               begin
                  state <= pab_pkg::ST_IDLE;
               end
            endcase
         end
      end
   end

   // Instruction answers
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         instr_rsp <= '0;
      end
      else if (ce)
      begin
         instr_rsp.done <= instr_req.valid;
         instr_rsp.spec_check <= spec_bad;
         instr_rsp.rejected <= ld_reject;
         instr_rsp.store_valid <= store_go;
         if (store_go)
         begin
            // Counter shows any stepping already done
            instr_rsp.store_word <= {8'h00, 1'b0, counter, blk, 8'h00,
                                     phys};
         end
      end
   end

   // Zero detect forces relocation, even for another area's address
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         acc_rsp <= '0;
      end
      else if (ce)
      begin
         acc_rsp.valid <= acc_req.valid;
         acc_rsp.relocated <= acc_req.valid &&
            acc_req.addr[pab_pkg::HI_MSB:pab_pkg::HI_LSB] == '0;
         if (acc_req.addr[pab_pkg::HI_MSB:pab_pkg::HI_LSB] == '0)
         begin
            acc_rsp.addr <= {1'b0, phys, blk,
               acc_req.addr[pab_pkg::OFF_MSB:0]};
         end
         else
         begin
            acc_rsp.addr <= acc_req.addr;
         end
      end
   end

   // Software registers; translation changes assume idle elements
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         cfg_mask <= pab_pkg::CFG_RESET;
         inhibit_logout_stop_bit <= 1'b0;
         mask <= '0;
         for (int i = 0; i < N_SLOTS; i++)
         begin
            addr_translation_table[i] <= '0;
         end
      end
      else if (ce && reg_wr)
      begin
         if (reg_addr == pab_pkg::REG_CONFIG)
         begin
            cfg_mask <= reg_wdata[pab_pkg::SE_COUNT-1:0];
            inhibit_logout_stop_bit <= reg_wdata[pab_pkg::CFG_INHIBIT_LOGOUT_STOP_BIT_BIT];
         end
         if (reg_addr == pab_pkg::REG_MASK)
         begin
            mask <= reg_wdata[pab_pkg::EV_W-1:0];
         end
         if (atr_hit(reg_addr))
         begin
            addr_translation_table[atr_index(reg_addr)] <=
               reg_wdata[pab_pkg::PHYS_W:0];
         end
      end
   end

   // Sticky events: a set in the clearing cycle survives
   always_comb
   begin
      events = '0;
      events[pab_pkg::ST_SPEC] = spec_bad;
      events[pab_pkg::ST_REJECT] = ld_reject;
      events[pab_pkg::ST_STEPPED] = ce && !load_go && !restart_event &&
         state == pab_pkg::ST_STEP && slot_ok(step_cnt);
      events[pab_pkg::ST_ELC] = ce && !load_go && !restart_event &&
         ((fail_go && alt_latch) || (state == pab_pkg::ST_STEP &&
         !slot_ok(step_cnt) && step_cnt == pab_pkg::STOP_SLOT &&
         nine_passes == pab_pkg::STOP_PASSES - 2'h1));
      next_status = status;
      if (ce && reg_wr && reg_addr == pab_pkg::REG_STATUS)
      begin
         next_status = status & ~reg_wdata[pab_pkg::EV_W-1:0];
      end
      next_status = next_status | events;
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         status <= '0;
         irq <= 1'b0;
      end
      else if (ce)
      begin
         status <= next_status;
         irq <= |(next_status & mask);
      end
   end

   // Read data one cycle after the strobe, zero otherwise
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         reg_rdata <= pab_pkg::WORD_ZERO;
      end
      else if (ce)
      begin
         reg_rdata <= pab_pkg::WORD_ZERO;
         if (reg_rd)
         begin
            case (reg_addr)
               pab_pkg::REG_STATUS:
                  reg_rdata[pab_pkg::EV_W-1:0] <= status;
               pab_pkg::REG_MASK:
                  reg_rdata[pab_pkg::EV_W-1:0] <= mask;
               pab_pkg::REG_CONFIG:
               begin
                  reg_rdata[pab_pkg::SE_COUNT-1:0] <= cfg_mask;
                  reg_rdata[pab_pkg::CFG_INHIBIT_LOGOUT_STOP_BIT_BIT] <= inhibit_logout_stop_bit;
               end
               pab_pkg::REG_BASE:
               begin
                  reg_rdata[pab_pkg::CNT_MSB:0] <= {counter, blk, 8'h00,
                                                    phys};
                  reg_rdata[pab_pkg::BASE_ALT_BIT] <= alt_latch;
                  reg_rdata[pab_pkg::BASE_HALT_BIT] <= hardstop;
               end
               default:
               begin
                  if (atr_hit(reg_addr))
                  begin
                     reg_rdata[pab_pkg::PHYS_W:0] <=
                        addr_translation_table[atr_index(reg_addr)];
                  end
               end
            endcase
         end
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   sequence s_fail_seen;
      fail_go && !alt_latch;
   endsequence

   sequence s_step_active;
      state == pab_pkg::ST_STEP;
   endsequence

   chk_load_sets_base: assert property (
      load_go |=> counter == $past(ld_cnt) && !alt_latch && !hardstop &&
                  blk == $past(instr_req.fetched[18:12]))
      else $error("load did not set base registers");

   chk_spec_suppress: assert property (
      spec_bad && state != pab_pkg::ST_STEP && !restart_event
      |=> instr_rsp.spec_check && !instr_rsp.store_valid &&
          $stable(counter) && $stable(phys))
      else $error("privilege or alignment fault not suppressed");

   chk_load_reject: assert property (
      ld_reject && !restart_event && state != pab_pkg::ST_STEP
      |=> instr_rsp.rejected && $stable(counter) && $stable(blk))
      else $error("bad slot load not rejected");

   chk_phys_hold: assert property (
      ce && state == pab_pkg::ST_IDLE && !load_go && !restart_event
      |=> $stable(phys))
      else $error("physical base changed without cause");

   chk_store_format: assert property (
      store_go |=> instr_rsp.store_valid &&
         instr_rsp.store_word[31:23] == 9'h000 &&
         instr_rsp.store_word[11:4] == 8'h00 &&
         instr_rsp.store_word[22:19] == $past(counter) &&
         instr_rsp.store_word[3:0] == $past(phys))
      else $error("stored base word malformed");

   chk_reloc_low: assert property (
      ce && acc_req.valid && acc_req.addr[23:12] == 12'h000
      |=> acc_rsp.relocated && acc_rsp.addr[22:19] == $past(phys) &&
          acc_rsp.addr[18:12] == $past(blk) &&
          acc_rsp.addr[11:0] == $past(acc_req.addr[11:0]))
      else $error("low address not relocated");

   chk_reloc_pass: assert property (
      ce && acc_req.valid && acc_req.addr[23:12] != 12'h000
      |=> !acc_rsp.relocated && acc_rsp.addr == $past(acc_req.addr))
      else $error("high address altered");

   chk_step_start: assert property (
      s_fail_seen |=> s_step_active)
      else $error("failure did not start stepping");

   chk_inhibit_logout_stop_bit_block: assert property (
      ce && inhibit_logout_stop_bit && state == pab_pkg::ST_IDLE
      |=> state != pab_pkg::ST_STEP)
      else $error("stepping despite inhibit");

   chk_step_advance: assert property (
      s_step_active and (ce && !load_go && !restart_event)
      |=> counter == $past(step_cnt) || (counter == 4'h0 && hardstop))
      else $error("counter did not advance one element");

   chk_step_lands: assert property (
      s_step_active and (ce && !load_go && !restart_event &&
      slot_ok(step_cnt)) |=> alt_latch && state == pab_pkg::ST_IDLE &&
      phys == $past(slot_id(step_cnt)))
      else $error("configured element not taken");

   chk_step_bounded: assert property (
      s_fail_seen ##1 (ce && !load_go && !restart_event)[*8]
      |-> ##[0:25] state != pab_pkg::ST_STEP || load_go || restart_event)
      else $error("stepping did not end");

   chk_alt_fail_halt: assert property (
      fail_go && alt_latch |=> hardstop && element_check_signal &&
                               state == pab_pkg::ST_HALT)
      else $error("alternate failure did not hardstop");

   chk_halt_freeze: assert property (
      state == pab_pkg::ST_HALT && !load_go && !restart_event
      |=> $stable(counter) && $stable(phys) && $stable(blk))
      else $error("base changed while halted");

endmodule : pab_base_reloc

// file: pab_se_model.sv
`timescale 1ns/10ps
module pab_se_model (
   // Clock
   input wire logic core_clk,
   // Relocated accesses seen by the elements
   input pab_pkg::pab_access_rsp_s acc_rsp,
   input wire logic [15:0] bad_se,
   // Failure report back to the processor
   output logic pref_fail
);
   // Broken element answers a relocated access with a failure
   always_ff @(posedge core_clk)
   begin
      pref_fail <= acc_rsp.valid && acc_rsp.relocated
         && bad_se[acc_rsp.addr[22:19]];
   end
endmodule : pab_se_model

// file: tb_top.sv
`timescale 1ns/10ps
module tb_top;
   logic core_clk, rst, ce, reg_wr, reg_rd, restart_event;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic [15:0] bad_se;
   pab_pkg::pab_instr_req_s instr_req;
   pab_pkg::pab_instr_rsp_s instr_rsp;
   pab_pkg::pab_access_req_s acc_req;
   pab_pkg::pab_access_rsp_s acc_rsp;
   logic pref_fail, hardstop, element_check_signal, irq;
   int error_cnt = 0;
   int n_compared = 0;
   int elc_cnt = 0;
   logic rd_seen = 1'b0;
   logic [31:0] q_rd[$], q_st[$], q_acc[$], q_in[$];
   logic [3:0] ids[10];

   pab_base_reloc u_pab_base_reloc (.core_clk(core_clk), .rst(rst),
      .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .instr_req(instr_req), .instr_rsp(instr_rsp), .acc_req(acc_req),
      .acc_rsp(acc_rsp), .pref_fail(pref_fail),
      .restart_event(restart_event), .hardstop(hardstop),
      .element_check_signal(element_check_signal), .irq(irq));
   pab_se_model u_pab_se_model (.core_clk(core_clk), .acc_rsp(acc_rsp),
      .bad_se(bad_se), .pref_fail(pref_fail));

   initial
   begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   task check(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
         error_cnt++;
      end
   endtask : check

   task results;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : results

   // Outputs of the previous cycle are judged against the oldest note
   always @(posedge core_clk)
   begin
      if (rd_seen)
         check("rdata", reg_rdata,
            q_rd.size() ? q_rd.pop_front() : 'x);
      rd_seen = reg_rd;
      if (instr_rsp.done)
         check("flags", {30'h0, instr_rsp.spec_check, instr_rsp.rejected},
            q_in.size() ? q_in.pop_front() : 'x);
      if (instr_rsp.store_valid)
         check("store", instr_rsp.store_word,
            q_st.size() ? q_st.pop_front() : 'x);
      if (acc_rsp.valid)
         check("acc", {7'h00, acc_rsp.relocated, acc_rsp.addr},
            q_acc.size() ? q_acc.pop_front() : 'x);
      if (element_check_signal)
         elc_cnt++;
   end

   task idle(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : idle

   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr

   task rd(input logic [7:0] a, input logic [31:0] e);
      q_rd.push_back(e);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
   endtask : rd

   task ins(input logic st, input logic sup, input logic nat,
      input logic [23:0] oa, input logic [31:0] f, input logic [1:0] e,
      input logic [31:0] sw);
      q_in.push_back({30'h0, e});
      if (st && e == 2'b00)
         q_st.push_back(sw);
      @(posedge core_clk);
      instr_req <= '{1'b1, st, sup, nat, oa, f};
      @(posedge core_clk);
      instr_req.valid <= 1'b0;
   endtask : ins

   task acc(input logic [23:0] a, input logic [23:0] e);
      q_acc.push_back({7'h00, a[23:12] == 12'h000, e});
      @(posedge core_clk);
      acc_req <= '{1'b1, a};
      @(posedge core_clk);
      acc_req.valid <= 1'b0;
   endtask : acc

   function logic [31:0] bw(input logic [3:0] c, input logic [6:0] b,
      input logic [3:0] p, input logic al, input logic hs);
      return {6'h00, hs, al, 1'b0, c, b, 8'h00, p};
   endfunction : bw

   function logic [31:0] lw(input logic [3:0] c, input logic [6:0] b);
      return {8'h00, 1'b1, c, b, 12'($urandom_range(4095, 0))};
   endfunction : lw

   initial
   begin
      #20000;
      error_cnt++;
      results();
   end

   initial
   begin
      logic [6:0] blk, blk2;
      logic [11:0] lo;
      logic [23:0] hi;
      void'($urandom(32'hcb87_be0c));
      {ce, rst, reg_wr, reg_rd, restart_event} = 5'b11000;
      reg_addr = 8'h00;
      reg_wdata = 32'h0000_0000;
      bad_se = 16'h0000;
      instr_req = '0;
      acc_req = '0;
      repeat (12) @(posedge core_clk);
      rst <= 1'b0;
      rd(pab_pkg::REG_BASE, 32'h0000_0000);
      rd(pab_pkg::REG_STATUS, 32'h0000_0000);
      rd(8'h44, 32'h0000_0000);
      $display("test reset done");
      // Translation set up with no traffic running
      for (int i = 0; i < 10; i++)
      begin
         ids[i] = 4'(i * 3 + 1);
         wr(8'(pab_pkg::REG_ATR0 + 4 * i), {27'h0, i != 7, ids[i]});
      end
      wr(pab_pkg::REG_CONFIG, 32'h0000_fbff);
      rd(8'h18, {27'h0, 1'b1, ids[2]});
      ins(0, 0, 1, 24'h000000, lw(2, 0), 2'b10, 0);
      ins(0, 1, 0, 24'h000000, lw(2, 0), 2'b10, 0);
      ins(0, 1, 1, 24'h000002, lw(2, 0), 2'b10, 0);
      ins(1, 0, 1, 24'h000000, 0, 2'b10, 0);
      ins(1, 1, 1, 24'h000001, 0, 2'b10, 0);
      ins(0, 1, 1, 24'h000000, lw(7, 0), 2'b01, 0);
      ins(0, 1, 1, 24'h000000, lw(3, 0), 2'b01, 0);
      ins(0, 1, 1, 24'h000000, lw(12, 0), 2'b01, 0);
      rd(pab_pkg::REG_BASE, 32'h0000_0000);
      rd(pab_pkg::REG_STATUS, 32'h0000_0003);
      wr(pab_pkg::REG_MASK, 32'h0000_0001);
      idle(2);
      check("irq", irq, 1);
      wr(pab_pkg::REG_STATUS, 32'h0000_0001);
      idle(2);
      check("irq", irq, 0);
      wr(pab_pkg::REG_STATUS, 32'h0000_0002);
      $display("test checks done");
      blk = 7'($urandom);
      ins(0, 1, 1, 24'h000004, lw(2, blk), 2'b00, 0);
      ins(1, 1, 1, 24'h000100, 0, 2'b00, {9'h0, 4'h2, blk, 8'h00, ids[2]});
      for (int i = 0; i < 4; i++)
      begin
         lo = 12'($urandom);
         hi = {12'($urandom_range(4095, 1)), lo};
         acc({12'h000, lo}, {1'b0, ids[2], blk, lo});
         acc(hi, hi);
      end
      $display("test load done");
      bad_se[ids[2]] <= 1'b1;
      acc(24'h000038, {1'b0, ids[2], blk, 12'h038});
      idle(40);
      rd(pab_pkg::REG_BASE, bw(4, blk, ids[4], 1, 0));
      rd(pab_pkg::REG_STATUS, 32'h0000_0004);
      ins(1, 1, 1, 24'h000200, 0, 2'b00, {9'h0, 4'h4, blk, 8'h00, ids[4]});
      acc(24'h000040, {1'b0, ids[4], blk, 12'h040});
      bad_se[ids[4]] <= 1'b1;
      acc(24'h000040, {1'b0, ids[4], blk, 12'h040});
      idle(5);
      check("halt", hardstop, 1);
      check("elc", elc_cnt, 1);
      rd(pab_pkg::REG_BASE, bw(4, blk, ids[4], 1, 1));
      $display("test step done");
      bad_se <= 16'h0000;
      blk2 = 7'($urandom);
      ins(0, 1, 1, 24'h000008, lw(8, blk2), 2'b00, 0);
      idle(2);
      check("halt", hardstop, 0);
      rd(pab_pkg::REG_BASE, bw(8, blk2, ids[8], 0, 0));
      wr(pab_pkg::REG_CONFIG, 32'h0001_ffff);
      bad_se <= 16'hffff;
      acc(24'h000010, {1'b0, ids[8], blk2, 12'h010});
      idle(30);
      rd(pab_pkg::REG_BASE, bw(8, blk2, ids[8], 0, 0));
      wr(pab_pkg::REG_STATUS, 32'h0000_000f);
      wr(pab_pkg::REG_CONFIG, 32'h0000_0000);
      acc(24'h000010, {1'b0, ids[8], blk2, 12'h010});
      idle(40);
      check("halt", hardstop, 1);
      check("elc", elc_cnt, 2);
      rd(pab_pkg::REG_BASE, bw(0, blk2, ids[8], 0, 1));
      rd(pab_pkg::REG_STATUS, 32'h0000_0008);
      $display("test wrap done");
      // Frozen clock enable must ignore the restart pulse
      @(posedge core_clk);
      ce <= 1'b0;
      restart_event <= 1'b1;
      idle(3);
      check("freeze", hardstop, 1);
      @(posedge core_clk);
      ce <= 1'b1;
      @(posedge core_clk);
      restart_event <= 1'b0;
      idle(2);
      check("halt", hardstop, 0);
      $display("test restart done");
      results();
   end
endmodule : tb_top
